//--- codec_irq_pkg.sv
package codec_irq_pkg;

   // Register addresses on the control port
   localparam logic [6:0] RX_FLAGS_ADDR = 7'h18;
   localparam logic [6:0] RX_EN_ADDR = 7'h19;
   localparam logic [6:0] CVT_FLAGS_ADDR = 7'h1A;
   localparam logic [6:0] CVT_EN_ADDR = 7'h1B;
   localparam logic [6:0] SUM_ADDR = 7'h1C;
   localparam logic [6:0] SUM_EN_ADDR = 7'h1D;

   // Receiver fault flag positions
   localparam int RX_VALIDITY_BIT = 7;
   localparam int RX_EMPHASIS_BIT = 6;
   localparam int RX_NONAUDIO_BIT = 5;
   localparam int RX_PREAMBLE_BIT = 4;
   localparam int RX_CHECKSUM_BIT = 3;
   localparam int RX_ABSENT_BIT = 2;
   localparam int RX_LINECODE_BIT = 1;
   localparam int RX_LOCK_BIT = 0;
   // Receiver flags that latch events; the rest follow a state
   localparam logic [7:0] RX_STICKY = 8'h0A;

   // Converter fault flag positions
   localparam int CVT_SLOW_BIT = 3;
   localparam int CVT_LCLIP_BIT = 2;
   localparam int CVT_RCLIP_BIT = 1;
   localparam int CVT_CLICK_BIT = 0;
   localparam logic [3:0] CVT_STICKY = 4'hE;
   localparam logic [3:0] CVT_EN_USED = 4'h7;

   // Summary bit positions
   localparam int SUM_CVT_BIT = 7;
   localparam int SUM_TXCOL_BIT = 6;
   localparam int SUM_TXUB_BIT = 5;
   localparam int SUM_TXBLK_BIT = 4;
   localparam int SUM_MISMATCH_BIT = 3;
   localparam int SUM_RXUB_BIT = 2;
   localparam int SUM_RXBLK_BIT = 1;
   localparam int SUM_RX_BIT = 0;
   // Summary bits that may drive the interrupt output
   localparam logic [7:0] SUM_IRQ_USED = 8'hF7;

   // Reset values and unmapped read value
   localparam logic [7:0] RX_EN_RESET = 8'h00;
   localparam logic [3:0] CVT_EN_RESET = 4'h0;
   localparam logic [7:0] SUM_EN_RESET = 8'h00;
   localparam logic [7:0] SUM_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;

endpackage

//--- flag_bank.sv
`timescale 1ns/10ps
module flag_bank
   import codec_irq_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] STICKY = '0
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Sources: pulses on sticky bits, levels on state bits
   input wire logic [WIDTH-1:0] flag_in,
   // Read of the flag register clears sticky bits and pending requests
   input wire logic rd_clr,
   input wire logic [WIDTH-1:0] enable,
   // Flag register view and combined interrupt
   output logic [WIDTH-1:0] flags,
   output logic irq_any
);

   typedef struct packed {
      logic [WIDTH-1:0] flags;
      logic [WIDTH-1:0] last;
      logic [WIDTH-1:0] pend;
      logic irq;
   } bank_s;

   bank_s q;
   bank_s d;
   logic [WIDTH-1:0] clr_v;
   logic [WIDTH-1:0] cause;

   always_comb begin
      clr_v = {WIDTH{rd_clr}};
      d = q;
      d.last = flag_in;
      // Sticky bits: set wins over the clearing read
      d.flags = (STICKY & ((q.flags & ~clr_v) | flag_in))
         | (~STICKY & flag_in);
      // State bits: only a change raises a new request
      d.pend = ((q.pend & ~clr_v) | (flag_in ^ q.last)) & ~STICKY;
      cause = (STICKY & q.flags) | (~STICKY & q.pend);
      d.irq = |(cause & enable);
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign flags = q.flags;
   assign irq_any = q.irq;

endmodule // flag_bank

//--- codec_irq_ctrl.sv
`timescale 1ns/10ps
// Function
// [RULE1] Receiver mask bit 1 lets its flag interrupt; 0 blocks it.
// [RULE2] Receiver mask bits match flag positions: validity bit 7, lock bit 0.
// [RULE3] Converter too-slow flag, bit 3, sets when convolution cycles run short.
// [RULE4] Left clip flag, bit 2, sets on clipping and holds until read.
// [RULE5] Right clip flag, bit 1, sets on clipping and holds until read.
// [RULE6] Click-risk flag, bit 0, follows fast mode; interrupts only on change.
// [RULE7] Host should mute converter output while fast mode is shown.
// [RULE8] Converter enables at bits 2..0; too-slow unmasked; bits 7..3 reserved.
// [RULE9] Summary bit 7 sets on converter interrupt, holds until summary read.
// [RULE10] Host reads converter flags promptly after summary bit 7.
// [RULE11] Summary bit 6 sets on status buffer write during copy.
// [RULE12] Summary bit 5 sets on transmit user buffer empty, holds until read.
// [RULE13] Summary bit 4 sets when status block sent, holds until read.
// [RULE14] Summary bit 3 sets on A/B status mismatch; never interrupts.
// [RULE15] Summary bit 2 sets on new receiver user block, holds until read.
// [RULE16] Summary bit 1: every new block if select 0, changes only if 1.
// [RULE17] Summary bit 0 sets on receiver interrupt, holds until summary read.
// [RULE18] Host reads receiver flags promptly after summary bit 0.
// [RULE19] Summary mask bit 1 lets its status bit interrupt; 0 records only.
// [RULE20] Line-code fault flag sets on biphase or parity error, holds until read.
// [RULE21] Lock, absent, emphasis flags keep value; interrupt again only on change.
// [RULE22] One interrupt output while any enabled status bit is set.
module codec_irq_ctrl
   import codec_irq_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Control port register access
   input wire logic [6:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Receiver condition inputs
   input wire logic receive_validity_flag,
   input wire logic rx_emphasis_state,
   input wire logic rx_nonaudio_state,
   input wire logic rx_preamble_state,
   input wire logic status_checksum_fault,
   input wire logic input_absent_flag,
   input wire logic rx_line_code_fault,
   input wire logic rx_lock_state,
   // Converter condition inputs
   input wire logic cvt_clock_too_slow,
   input wire logic left_clip_flag,
   input wire logic right_clip_flag,
   input wire logic click_risk_flag,
   // Buffer and channel status events
   input wire logic tx_status_write_collision,
   input wire logic tx_user_buffer_empty,
   input wire logic tx_status_block_done,
   input wire logic rx_status_mismatch,
   input wire logic rx_user_block_ready,
   input wire logic rx_status_block_new,
   input wire logic rx_status_changed,
   input wire logic rx_status_event_select,
   // Interrupt output
   output logic irq_out
);

   typedef struct packed {
      logic [7:0] rx_en;
      logic [3:0] cvt_en;
      logic [7:0] sum_en;
      logic [7:0] summary;
      logic [7:0] rdata;
      logic irq;
   } ctrl_s;

   ctrl_s q;
   ctrl_s d;

   logic [7:0] rx_in;
   logic [3:0] cvt_in;
   logic [7:0] rx_flags;
   logic [3:0] cvt_flags;
   logic rx_irq;
   logic cvt_irq;
   logic rx_rd;
   logic cvt_rd;
   logic sum_rd;
   logic [7:0] sum_set;

   function automatic logic hit(input logic [6:0] addr,
                                input logic [6:0] target);
      hit = (addr == target);
   endfunction

   // Receiver flag sources in register bit order
   always_comb begin
      rx_in = '0;
      rx_in[RX_VALIDITY_BIT] = receive_validity_flag; // RULE2
      rx_in[RX_EMPHASIS_BIT] = rx_emphasis_state;
      rx_in[RX_NONAUDIO_BIT] = rx_nonaudio_state;
      rx_in[RX_PREAMBLE_BIT] = rx_preamble_state;
      rx_in[RX_CHECKSUM_BIT] = status_checksum_fault;
      rx_in[RX_ABSENT_BIT] = input_absent_flag;
      rx_in[RX_LINECODE_BIT] = rx_line_code_fault; // RULE20
      rx_in[RX_LOCK_BIT] = rx_lock_state; // RULE2
   end

   always_comb begin
      cvt_in = '0;
      cvt_in[CVT_SLOW_BIT] = cvt_clock_too_slow; // RULE3
      cvt_in[CVT_LCLIP_BIT] = left_clip_flag; // RULE4
      cvt_in[CVT_RCLIP_BIT] = right_clip_flag; // RULE5
      cvt_in[CVT_CLICK_BIT] = click_risk_flag; // RULE6
   end

   assign rx_rd = reg_rd && hit(reg_addr, RX_FLAGS_ADDR);
   assign cvt_rd = reg_rd && hit(reg_addr, CVT_FLAGS_ADDR);
   assign sum_rd = reg_rd && hit(reg_addr, SUM_ADDR);

   // Receiver flags: checksum and line-code latch, others track state
   flag_bank #(
      .WIDTH(8),
      .STICKY(RX_STICKY)
   ) rx_bank (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .flag_in(rx_in), // RULE21
      .rd_clr(rx_rd), // RULE20
      .enable(q.rx_en), // RULE1
      .flags(rx_flags),
      .irq_any(rx_irq)
   );

   // Too-slow has no enable bit, so it never reaches the interrupt
   flag_bank #(
      .WIDTH(4),
      .STICKY(CVT_STICKY)
   ) cvt_bank (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .flag_in(cvt_in), // RULE6
      .rd_clr(cvt_rd), // RULE4 RULE5
      .enable({1'b0, q.cvt_en[2:0]}), // RULE8
      .flags(cvt_flags),
      .irq_any(cvt_irq)
   );

   // Summary set sources
   always_comb begin
      sum_set = '0;
      sum_set[SUM_CVT_BIT] = cvt_irq; // RULE9
      sum_set[SUM_TXCOL_BIT] = tx_status_write_collision; // RULE11
      sum_set[SUM_TXUB_BIT] = tx_user_buffer_empty; // RULE12
      sum_set[SUM_TXBLK_BIT] = tx_status_block_done; // RULE13
      sum_set[SUM_MISMATCH_BIT] = rx_status_mismatch; // RULE14
      sum_set[SUM_RXUB_BIT] = rx_user_block_ready; // RULE15
      if (rx_status_event_select) begin
         sum_set[SUM_RXBLK_BIT] = rx_status_changed; // RULE16
      end else begin
         sum_set[SUM_RXBLK_BIT] = rx_status_block_new; // RULE16
      end
      sum_set[SUM_RX_BIT] = rx_irq; // RULE17
   end

   always_comb begin
      d = q;
      // Writes to mask registers; flag registers are read-only
      if (reg_wr) begin
         if (hit(reg_addr, RX_EN_ADDR)) begin
            d.rx_en = reg_wdata; // RULE2
         end else if (hit(reg_addr, CVT_EN_ADDR)) begin
            d.cvt_en = reg_wdata[3:0] & CVT_EN_USED; // RULE8
         end else if (hit(reg_addr, SUM_EN_ADDR)) begin
            d.sum_en = reg_wdata & SUM_IRQ_USED;
         end
      end
      // Read data captured on the read strobe
      if (reg_rd) begin
         if (hit(reg_addr, RX_FLAGS_ADDR)) begin
            d.rdata = rx_flags;
         end else if (hit(reg_addr, RX_EN_ADDR)) begin
            d.rdata = q.rx_en;
         end else if (hit(reg_addr, CVT_FLAGS_ADDR)) begin
            d.rdata = {4'h0, cvt_flags};
         end else if (hit(reg_addr, CVT_EN_ADDR)) begin
            d.rdata = {4'h0, q.cvt_en};
         end else if (hit(reg_addr, SUM_ADDR)) begin
            d.rdata = q.summary;
         end else if (hit(reg_addr, SUM_EN_ADDR)) begin
            d.rdata = q.sum_en;
         end else begin
            d.rdata = UNMAPPED_DATA;
         end
      end
      // Sticky summary: a new event beats the clearing read
      d.summary = (q.summary & ~{8{sum_rd}}) | sum_set; // RULE9 RULE17
      // Mismatch bit is excluded from the enable set
      d.irq = |(q.summary & q.sum_en & SUM_IRQ_USED); // RULE19 RULE22
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q.rx_en <= RX_EN_RESET;
         q.cvt_en <= CVT_EN_RESET;
         q.sum_en <= SUM_EN_RESET;
         q.summary <= SUM_RESET;
         q.rdata <= UNMAPPED_DATA;
         q.irq <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata = q.rdata;
   assign irq_out = q.irq;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   rx_mask_gate_a: assert property ( // RULE1
      $past(q.rx_en) == 8'h00 && q.rx_en == 8'h00 |-> !rx_irq
   ) else $error("receiver interrupt with all masks clear");

   slow_flag_set_a: assert property ( // RULE3
      cvt_clock_too_slow |=> cvt_flags[CVT_SLOW_BIT]
   ) else $error("too-slow event not latched");

   left_clip_hold_a: assert property ( // RULE4
      cvt_flags[CVT_LCLIP_BIT] && !cvt_rd |=> cvt_flags[CVT_LCLIP_BIT]
   ) else $error("left clip flag lost before read");

   right_clip_hold_a: assert property ( // RULE5
      right_clip_flag ##1 !cvt_rd [*3] |-> cvt_flags[CVT_RCLIP_BIT]
   ) else $error("right clip flag lost before read");

   click_follow_a: assert property ( // RULE6
      cvt_flags[CVT_CLICK_BIT] == $past(click_risk_flag)
   ) else $error("click-risk flag does not track fast mode");

   cvt_reserved_a: assert property ( // RULE8
      reg_wr && hit(reg_addr, CVT_EN_ADDR) |=> q.cvt_en[3] == 1'b0
   ) else $error("reserved converter enable bit stored");

   cvt_summary_a: assert property ( // RULE9
      cvt_irq |=> q.summary[SUM_CVT_BIT]
   ) else $error("converter interrupt not in summary");

   mismatch_quiet_a: assert property ( // RULE14
      (q.summary & q.sum_en & ~(8'h01 << SUM_MISMATCH_BIT)) == 8'h00
         |=> !q.irq
   ) else $error("interrupt without enabled cause");

   block_select_a: assert property ( // RULE16
      rx_status_event_select && !rx_status_changed
         && !q.summary[SUM_RXBLK_BIT] |=> !q.summary[SUM_RXBLK_BIT]
   ) else $error("block bit set without change in change mode");

   rx_summary_a: assert property ( // RULE17
      rx_irq |=> q.summary[SUM_RX_BIT]
   ) else $error("receiver interrupt not in summary");

   irq_cause_a: assert property ( // RULE22
      q.summary[SUM_TXUB_BIT] && q.sum_en[SUM_TXUB_BIT] |=> q.irq
   ) else $error("enabled status bit did not raise interrupt");

   rx_mask_pass_a: assert property ( // RULE1
      rx_flags[RX_LINECODE_BIT] && q.rx_en[RX_LINECODE_BIT] |=> rx_irq
   ) else $error("enabled receiver flag did not interrupt");

   lock_position_a: assert property ( // RULE2
      rx_lock_state |=> rx_flags[RX_LOCK_BIT]
   ) else $error("lock state not at its flag position");

   validity_position_a: assert property ( // RULE2
      receive_validity_flag |=> rx_flags[RX_VALIDITY_BIT]
   ) else $error("validity state not at its flag position");

   rx_en_store_a: assert property ( // RULE2
      reg_wr && hit(reg_addr, RX_EN_ADDR) |=> q.rx_en == $past(reg_wdata)
   ) else $error("receiver enable write not stored");

   slow_hold_a: assert property ( // RULE3
      cvt_flags[CVT_SLOW_BIT] && !cvt_rd |=> cvt_flags[CVT_SLOW_BIT]
   ) else $error("too-slow flag lost before read");

   left_clip_set_a: assert property ( // RULE4
      left_clip_flag |=> cvt_flags[CVT_LCLIP_BIT]
   ) else $error("left clip event not latched");

   left_clip_clear_a: assert property ( // RULE4
      cvt_rd && !left_clip_flag |=> !cvt_flags[CVT_LCLIP_BIT]
   ) else $error("left clip flag not cleared by read");

   right_clip_set_a: assert property ( // RULE5
      right_clip_flag |=> cvt_flags[CVT_RCLIP_BIT]
   ) else $error("right clip event not latched");

   click_quiet_a: assert property ( // RULE6
      cvt_rd && $stable(click_risk_flag) ##1 !q.cvt_en[CVT_LCLIP_BIT]
         && !q.cvt_en[CVT_RCLIP_BIT] |=> !cvt_irq
   ) else $error("click-risk flag raised a request without change");

   slow_unmasked_a: assert property ( // RULE8
      !cvt_flags[CVT_LCLIP_BIT] && !cvt_flags[CVT_RCLIP_BIT]
         && !q.cvt_en[CVT_CLICK_BIT] |=> !cvt_irq
   ) else $error("too-slow flag reached the interrupt");

   cvt_en_store_a: assert property ( // RULE8
      reg_wr && hit(reg_addr, CVT_EN_ADDR)
         |=> q.cvt_en[2:0] == $past(reg_wdata[2:0])
   ) else $error("converter enable write not stored");

   cvt_summary_hold_a: assert property ( // RULE9
      q.summary[SUM_CVT_BIT] && !sum_rd |=> q.summary[SUM_CVT_BIT]
   ) else $error("converter summary bit lost before read");

   collision_set_a: assert property ( // RULE11
      tx_status_write_collision |=> q.summary[SUM_TXCOL_BIT]
   ) else $error("status write collision not in summary");

   tx_empty_set_a: assert property ( // RULE12
      tx_user_buffer_empty |=> q.summary[SUM_TXUB_BIT]
   ) else $error("user buffer empty not in summary");

   block_done_set_a: assert property ( // RULE13
      tx_status_block_done |=> q.summary[SUM_TXBLK_BIT]
   ) else $error("status block done not in summary");

   mismatch_set_a: assert property ( // RULE14
      rx_status_mismatch |=> q.summary[SUM_MISMATCH_BIT]
   ) else $error("status mismatch not in summary");

   rx_user_set_a: assert property ( // RULE15
      rx_user_block_ready |=> q.summary[SUM_RXUB_BIT]
   ) else $error("receiver user block not in summary");

   block_new_a: assert property ( // RULE16
      !rx_status_event_select && rx_status_block_new
         |=> q.summary[SUM_RXBLK_BIT]
   ) else $error("new status block not in summary");

   summary_clear_a: assert property ( // RULE17
      sum_rd && sum_set == 8'h00 |=> q.summary == 8'h00
   ) else $error("summary not cleared by read");

   sum_mask_off_a: assert property ( // RULE19
      q.sum_en == 8'h00 |=> !q.irq
   ) else $error("interrupt with all summary masks clear");

   line_code_set_a: assert property ( // RULE20
      rx_line_code_fault |=> rx_flags[RX_LINECODE_BIT]
   ) else $error("line-code fault not latched");

   absent_track_a: assert property ( // RULE21
      rx_flags[RX_ABSENT_BIT] == $past(input_absent_flag)
   ) else $error("input-absent flag does not track its state");

   irq_raise_a: assert property ( // RULE22
      (q.summary & q.sum_en & SUM_IRQ_USED) != 8'h00 |=> q.irq
   ) else $error("enabled summary bit did not raise interrupt");

endmodule // codec_irq_ctrl

//--- tb.sv
`timescale 1ns/10ps
module tb;
   import codec_irq_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   // Sources: [18:12] events, [11:8] converter, [7:0] receiver
   logic [18:0] src = '0;
   logic sel = 1'b0;
   logic irq_out;
   int err_total = 0;
   int n_compared = 0;

   always #5 clk_sys = ~clk_sys;

   codec_irq_ctrl u_dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .receive_validity_flag(src[7]),
      .rx_emphasis_state(src[6]), .rx_nonaudio_state(src[5]),
      .rx_preamble_state(src[4]), .status_checksum_fault(src[3]),
      .input_absent_flag(src[2]), .rx_line_code_fault(src[1]),
      .rx_lock_state(src[0]), .cvt_clock_too_slow(src[11]),
      .left_clip_flag(src[10]), .right_clip_flag(src[9]),
      .click_risk_flag(src[8]), .tx_status_write_collision(src[18]),
      .tx_user_buffer_empty(src[17]), .tx_status_block_done(src[16]),
      .rx_status_mismatch(src[15]), .rx_user_block_ready(src[14]),
      .rx_status_block_new(src[13]), .rx_status_changed(src[12]),
      .rx_status_event_select(sel), .irq_out(irq_out));

   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk8(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_irq(input logic exp);
      #1;
      n_compared++;
      if (irq_out !== exp) begin
         err_total++;
         $display("MISMATCH irq_out expected %b seen %b", exp, irq_out);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // Read result is registered; look one edge after it lands
   task automatic rd(input logic [6:0] a, input logic [7:0] exp,
                     input string what);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk8(what, exp, reg_rdata);
   endtask

   task automatic set_src(input int i, input logic v);
      @(posedge clk_sys);
      src[i] <= v;
      tick(6);
   endtask

   task automatic pulse(input int i);
      @(posedge clk_sys);
      src[i] <= 1'b1;
      @(posedge clk_sys);
      src[i] <= 1'b0;
      tick(6);
   endtask

   initial begin
      #100000;
      err_total++;
      tally_and_finish();
   end

   initial begin
      logic [7:0] m;
      tick(3);
      rst_b <= 1'b1;
      rd(RX_EN_ADDR, RX_EN_RESET, "rx_en reset");
      rd(CVT_EN_ADDR, {4'h0, CVT_EN_RESET}, "cvt_en reset");
      rd(SUM_EN_ADDR, SUM_EN_RESET, "sum_en reset");
      rd(SUM_ADDR, SUM_RESET, "summary reset");
      rd(7'h30, UNMAPPED_DATA, "unmapped");
      chk_irq(1'b0);
      wr(RX_EN_ADDR, 8'hA5);
      rd(RX_EN_ADDR, 8'hA5, "rx_en rw");
      wr(CVT_EN_ADDR, 8'hFF);
      rd(CVT_EN_ADDR, 8'h07, "cvt_en rw");
      wr(SUM_EN_ADDR, 8'hFF);
      rd(SUM_EN_ADDR, 8'hF7, "sum_en rw");
      wr(SUM_ADDR, 8'hFF);
      rd(SUM_ADDR, 8'h00, "summary ro");
      wr(CVT_FLAGS_ADDR, 8'hFF);
      rd(CVT_FLAGS_ADDR, 8'h00, "cvt ro");
      $display("test registers done");
      // Left clip through both masks
      wr(CVT_EN_ADDR, 8'h07);
      wr(SUM_EN_ADDR, 8'h80);
      pulse(10);
      chk_irq(1'b1);
      rd(CVT_FLAGS_ADDR, 8'h04, "left clip");
      tick(4);
      rd(SUM_ADDR, 8'h80, "cvt summary");
      rd(SUM_ADDR, 8'h00, "cvt summary clr");
      tick(2);
      chk_irq(1'b0);
      // Right clip masked, too-slow never interrupts
      wr(CVT_EN_ADDR, 8'h05);
      pulse(9);
      pulse(11);
      chk_irq(1'b0);
      rd(SUM_ADDR, 8'h00, "masked cvt");
      rd(CVT_FLAGS_ADDR, 8'h0A, "rclip slow");
      rd(CVT_FLAGS_ADDR, 8'h00, "rclip clr");
      $display("test clip done");
      // Click risk follows fast mode, interrupts on change only
      wr(CVT_EN_ADDR, 8'h01);
      set_src(8, 1'b1);
      chk_irq(1'b1);
      rd(CVT_FLAGS_ADDR, 8'h01, "click set");
      tick(4);
      rd(SUM_ADDR, 8'h80, "click summary");
      rd(SUM_ADDR, 8'h00, "click no repeat");
      rd(CVT_FLAGS_ADDR, 8'h01, "click held");
      set_src(8, 1'b0);
      rd(CVT_FLAGS_ADDR, 8'h00, "click fell");
      tick(4);
      rd(SUM_ADDR, 8'h80, "click change");
      rd(SUM_ADDR, 8'h00, "click change clr");
      $display("test click done");
      // Direct summary sources, enabled then masked
      for (int p = 0; p < 2; p++) begin
         m = (p == 0) ? 8'hFF : 8'h00;
         wr(SUM_EN_ADDR, m);
         for (int i = 2; i <= 6; i++) begin
            pulse(i + 12);
            chk_irq(m[0] && i != 3);
            rd(SUM_ADDR, 8'h01 << i, "summary src");
            rd(SUM_ADDR, 8'h00, "summary clr");
            tick(2);
            chk_irq(1'b0);
         end
      end
      $display("test summary done");
      // Channel status block event selection
      for (int s = 0; s < 2; s++) begin
         @(posedge clk_sys);
         sel <= s[0];
         pulse(12);
         rd(SUM_ADDR, s[0] ? 8'h02 : 8'h00, "cs changed");
         pulse(13);
         rd(SUM_ADDR, s[0] ? 8'h00 : 8'h02, "cs new");
      end
      $display("test select done");
      // Receiver line-code fault
      wr(SUM_EN_ADDR, 8'h01);
      wr(RX_EN_ADDR, 8'h02);
      pulse(1);
      chk_irq(1'b1);
      rd(RX_FLAGS_ADDR, 8'h02, "line code");
      tick(4);
      rd(SUM_ADDR, 8'h01, "rx summary");
      rd(SUM_ADDR, 8'h00, "rx summary clr");
      rd(RX_FLAGS_ADDR, 8'h00, "line code clr");
      // Lock state keeps its value after read
      wr(RX_EN_ADDR, 8'h01);
      set_src(0, 1'b1);
      chk_irq(1'b1);
      rd(RX_FLAGS_ADDR, 8'h01, "lock");
      tick(4);
      rd(SUM_ADDR, 8'h01, "lock summary");
      rd(SUM_ADDR, 8'h00, "lock no repeat");
      rd(RX_FLAGS_ADDR, 8'h01, "lock held");
      // Validity masked, then enabled at bit 7
      set_src(7, 1'b1);
      chk_irq(1'b0);
      rd(SUM_ADDR, 8'h00, "validity masked");
      rd(RX_FLAGS_ADDR, 8'h81, "validity");
      wr(RX_EN_ADDR, 8'h80);
      set_src(7, 1'b0);
      chk_irq(1'b1);
      rd(RX_FLAGS_ADDR, 8'h01, "validity fell");
      tick(4);
      rd(SUM_ADDR, 8'h01, "validity summary");
      rd(SUM_ADDR, 8'h00, "validity clr");
      // Remaining receiver bits in their positions
      for (int i = 2; i <= 6; i++) begin
         set_src(i, 1'b1);
         rd(RX_FLAGS_ADDR, 8'h01 | (8'h01 << i), "rx bit set");
         set_src(i, 1'b0);
         rd(RX_FLAGS_ADDR, RX_STICKY[i] ? 8'h01 | (8'h01 << i) : 8'h01,
            "rx bit fell");
      end
      // Reset in mid-run returns masks and outputs to idle
      @(posedge clk_sys);
      rst_b <= 1'b0;
      tick(3);
      rst_b <= 1'b1;
      rd(RX_EN_ADDR, RX_EN_RESET, "rx_en after reset");
      rd(SUM_ADDR, SUM_RESET, "summary after reset");
      chk_irq(1'b0);
      $display("test receiver done");
      tally_and_finish();
   end
endmodule // tb
